// [dlt_pkg.sv]
// dlt_pkg: constants for the ddr read latency parameter block
// assumes: shared by both ends of the table link
package dlt_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] OFS_ID = 6'h00;
    localparam logic [5:0] OFS_LEN = 6'h01;
    localparam logic [5:0] OFS_ROWS = 6'h02;
    localparam logic [5:0] OFS_ROWLEN = 6'h03;
    localparam logic [5:0] OFS_TABLE = 6'h04;
    localparam logic [5:0] OFS_LAST = 6'h2B;
    localparam logic [7:0] PARAM_ID = 8'h9A;
    localparam logic [7:0] PARAM_LEN = 8'h2A;
    localparam logic [7:0] NUM_ROWS = 8'h05;
    localparam logic [7:0] ROW_LEN = 8'h08;
    localparam logic [7:0] HDR_FREQ = 8'h46;
    localparam logic [7:0] HDR_CODE = 8'h43;
    localparam logic [7:0] CMD_FAST3 = 8'h0D;
    localparam logic [7:0] CMD_FAST4 = 8'h0E;
    localparam logic [7:0] CMD_DUAL3 = 8'hBD;
    localparam logic [7:0] CMD_DUAL4 = 8'hBE;
    localparam logic [7:0] CMD_QUAD3 = 8'hED;
    localparam logic [7:0] CMD_QUAD4 = 8'hEE;
    localparam logic [7:0] NOT_SUPPORTED = 8'hFF;
    localparam logic [7:0] MHZ_50 = 8'h32;
    localparam logic [7:0] MHZ_66 = 8'h42;
    localparam logic [7:0] LC_11 = 8'h03;
    localparam logic [7:0] LC_00 = 8'h00;
    localparam logic [7:0] LC_01 = 8'h01;
    localparam logic [7:0] LC_10 = 8'h02;
    localparam logic [7:0] MODE_FAST = 8'h04;
    localparam logic [7:0] MODE_DUAL = 8'h02;
    localparam logic [7:0] MODE_QUAD = 8'h01;
    localparam logic [1:0] SEL_FAST = 2'h0;
    localparam logic [1:0] SEL_DUAL = 2'h1;
    localparam logic [1:0] SEL_QUAD = 2'h2;
endpackage

// [dlt_if.sv]
// dlt_if: byte read link between table host and table device
// assumes: one clock, device answers one cycle after a request
`timescale 1ns/1ps
interface dlt_if;
    logic req;
    logic [5:0] addr;
    logic ack;
    logic [7:0] data;
    modport dev (input req, input addr, output ack, output data);
    modport host (output req, output addr, input ack, input data);
endinterface

// [dlt_device.sv]
// dlt_device: read-only ddr latency code table, one byte per request
// assumes: host keeps one request outstanding and waits for ack
// How it works
// RULE1: byte 00h returns identifier 9Ah
// RULE2: byte 01h returns length 2Ah
// RULE3: header opens with ASCII F and C
// RULE4: header lists fast ddr codes 0Dh, 0Eh
// RULE5: header lists dual ddr codes BDh, BEh
// RULE6: header lists quad ddr codes EDh, EEh
// RULE7: code 11b row: 50 MHz, cycles 4/1,2/2,1/3
// RULE8: code 00b row: 66 MHz, cycles 4/2,2/4,1/6
// RULE9: code 01b row: 66 MHz, cycles 4/4,2/5,1/7
// RULE10: code 10b row: 66 MHz, cycles 4/5,2/6,1/8
// RULE11: five eight-byte rows from byte 04h
// RULE12: cycle entry FFh means command unsupported
// RULE13: fixed bytes, read in ascending address order
`timescale 1ns/1ps
module dlt_device (
    input wire logic clk_i,
    input wire logic rst_i,
    dlt_if.dev link
);
    import dlt_pkg::*;
    logic ack;
    logic [7:0] data;
    logic next_ack;
    logic [7:0] next_data;
    logic [7:0] rom;
    assign link.ack = ack;
    assign link.data = data;
    always_comb begin
        unique case (link.addr)
            OFS_ID: rom = PARAM_ID; // RULE1
            OFS_LEN: rom = PARAM_LEN; // RULE2
            OFS_ROWS: rom = NUM_ROWS; // RULE11
            OFS_ROWLEN: rom = ROW_LEN; // RULE11
            6'h04: rom = HDR_FREQ; // RULE3
            6'h05: rom = HDR_CODE; // RULE3
            6'h06: rom = CMD_FAST3; // RULE4
            6'h07: rom = CMD_FAST4; // RULE4
            6'h08: rom = CMD_DUAL3; // RULE5
            6'h09: rom = CMD_DUAL4; // RULE5
            6'h0A: rom = CMD_QUAD3; // RULE6
            6'h0B: rom = CMD_QUAD4; // RULE6
            6'h0C: rom = MHZ_50; // RULE7
            6'h0D: rom = LC_11; // RULE7
            6'h0E: rom = MODE_FAST; // RULE7
            6'h0F: rom = 8'h01; // RULE7
            6'h10: rom = MODE_DUAL; // RULE7
            6'h11: rom = 8'h02; // RULE7
            6'h12: rom = MODE_QUAD; // RULE7
            6'h13: rom = 8'h03; // RULE7
            6'h14: rom = MHZ_66; // RULE8
            6'h15: rom = LC_00; // RULE8
            6'h16: rom = MODE_FAST; // RULE8
            6'h17: rom = 8'h02; // RULE8
            6'h18: rom = MODE_DUAL; // RULE8
            6'h19: rom = 8'h04; // RULE8
            6'h1A: rom = MODE_QUAD; // RULE8
            6'h1B: rom = 8'h06; // RULE8
            6'h1C: rom = MHZ_66; // RULE9
            6'h1D: rom = LC_01; // RULE9
            6'h1E: rom = MODE_FAST; // RULE9
            6'h1F: rom = 8'h04; // RULE9
            6'h20: rom = MODE_DUAL; // RULE9
            6'h21: rom = 8'h05; // RULE9
            6'h22: rom = MODE_QUAD; // RULE9
            6'h23: rom = 8'h07; // RULE9
            6'h24: rom = MHZ_66; // RULE10
            6'h25: rom = LC_10; // RULE10
            6'h26: rom = MODE_FAST; // RULE10
            6'h27: rom = 8'h05; // RULE10
            6'h28: rom = MODE_DUAL; // RULE10
            6'h29: rom = 8'h06; // RULE10
            6'h2A: rom = MODE_QUAD; // RULE10
            6'h2B: rom = 8'h08; // RULE10
            // past the block reads as unsupported, never as a stale byte
            default: rom = NOT_SUPPORTED; // RULE12
        endcase
    end
    always_comb begin
        next_ack = link.req; // RULE13
        next_data = link.req ? rom : data; // RULE13
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            data <= 8'h00;
        end else begin
            ack <= next_ack;
            data <= next_data;
        end
    end
endmodule

// [dlt_host.sv]
// dlt_host: walks the table and picks ddr mode and latency for a latency code; freq_o is the last row's limit
// assumes: device answers each request with ack one cycle later
`timescale 1ns/1ps
module dlt_host (
    input wire logic clk_i,
    input wire logic rst_i,
    dlt_if.host link,
    input wire logic start_i,
    input wire logic [1:0] code_i,
    input wire logic [1:0] cmd_sel_i,
    output logic done_o,
    output logic found_o,
    output logic supported_o,
    output logic [7:0] freq_o,
    output logic [7:0] mode_o,
    output logic [7:0] lat_o
);
    import dlt_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_REQ = 2'b01, ST_WAIT = 2'b10
    } dlt_state_e;
    dlt_state_e state, next_state;
    logic [5:0] addr, next_addr;
    logic req, next_req;
    logic done, next_done, found, next_found, sup, next_sup;
    logic [7:0] freq, next_freq, mode, next_mode, lat, next_lat;
    logic hit, next_hit;
    logic [5:0] row_pos;
    logic [5:0] mode_pos;
    assign link.req = req;
    assign link.addr = addr;
    assign done_o = done;
    assign found_o = found;
    assign supported_o = sup;
    assign freq_o = freq;
    assign mode_o = mode;
    assign lat_o = lat;
    // offset within a data row; header row is skipped by starting past it
    always_comb begin
        row_pos = 6'((addr - OFS_TABLE) & 6'h07);
        mode_pos = 6'(6'h02 + {3'b000, cmd_sel_i, 1'b0});
    end
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_req = 1'b0;
        next_done = 1'b0;
        next_found = found;
        next_sup = sup;
        next_freq = freq;
        next_mode = mode;
        next_lat = lat;
        next_hit = hit;
        unique case (state)
            ST_IDLE: begin
                if (start_i) begin
                    next_addr = 6'(OFS_TABLE + 6'h08); // RULE11
                    next_found = 1'b0;
                    next_sup = 1'b0;
                    next_hit = 1'b0;
                    next_req = 1'b1;
                    next_state = ST_REQ;
                end
            end
            ST_REQ: next_state = ST_WAIT;
            ST_WAIT: begin
                if (link.ack) begin
                    if (row_pos == 6'h00) next_freq = link.data; // RULE7
                    if (row_pos == 6'h01) begin
                        next_hit = link.data[1:0] == code_i; // RULE8
                    end
                    if (hit && row_pos == mode_pos) begin
                        next_mode = link.data; // RULE9
                    end
                    if (hit && row_pos == 6'(mode_pos + 6'h01)) begin
                        next_lat = link.data; // RULE10
                        next_found = 1'b1;
                        next_sup = link.data != NOT_SUPPORTED // RULE12
                            && mode != NOT_SUPPORTED;
                    end
                    if (addr == OFS_LAST) begin
                        next_done = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_addr = 6'(addr + 6'h01); // RULE13
                        next_req = 1'b1;
                        next_state = ST_REQ;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            addr <= 6'h00;
            req <= 1'b0;
            done <= 1'b0;
            found <= 1'b0;
            sup <= 1'b0;
            freq <= 8'h00;
            mode <= 8'h00;
            lat <= 8'h00;
            hit <= 1'b0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            req <= next_req;
            done <= next_done;
            found <= next_found;
            sup <= next_sup;
            freq <= next_freq;
            mode <= next_mode;
            lat <= next_lat;
            hit <= next_hit;
        end
    end
endmodule

// [dlt_assertions.sv]
// dlt_assertions: checks on the link between table host and device
// assumes: plain link signals, one clock, sync reset active high
`timescale 1ns/1ps
module dlt_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic [5:0] addr,
    input wire logic ack,
    input wire logic [7:0] data
);
    import dlt_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd(logic [5:0] a);
        req && addr == a;
    endsequence
    sequence s_ans(logic [7:0] v);
        ack && data == v;
    endsequence
    property p_byte(logic [5:0] a, logic [7:0] v);
        s_rd(a) |=> s_ans(v);
    endproperty
    a_ack_next: assert property (req |=> ack)
        else $error("ack missing after request");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_one_request: assert property (req |=> !req)
        else $error("second request outstanding");
    a_data_held: assert property (!ack |-> $stable(data))
        else $error("data moved without ack");
    a_row2_freq: assert property (p_byte(6'h0C, MHZ_50))
        else $error("row two limit wrong");
    a_row2_code: assert property (p_byte(6'h0D, LC_11))
        else $error("row two code wrong");
    a_row3_freq: assert property (p_byte(6'h14, MHZ_66))
        else $error("row three limit wrong");
    a_row3_quad: assert property (p_byte(6'h1B, 8'h06))
        else $error("row three quad latency wrong");
    a_row4_code: assert property (p_byte(6'h1D, LC_01))
        else $error("row four code wrong");
    a_row5_quad: assert property (p_byte(6'h2B, 8'h08))
        else $error("row five quad latency wrong");
endmodule

// [test_ddr_read_latency_table.sv]
// test_ddr_read_latency_table: host walks the table; a second device
// is read byte by byte from the bench
// assumes: dlt_pkg, dlt_if, dlt_device, dlt_host, dlt_assertions
`timescale 1ns/1ps
module test_ddr_read_latency_table;
    import dlt_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic start_i = 0;
    logic [1:0] code_i = 0;
    logic [1:0] cmd_sel_i = 0;
    logic done_o, found_o, supported_o;
    logic [7:0] freq_o, mode_o, lat_o;
    logic [5:0] last_a = 0;
    logic [25:0] exp_r;
    logic [25:0] res_q[$];
    logic [7:0] byte_q[$];
    int failures = 0;
    int comparisons = 0;
    int dones = 0;
    int seed = 91750;
    logic [7:0] rom [0:43] = '{8'h9A, 8'h2A, 8'h05, 8'h08,
        8'h46, 8'h43, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE,
        8'h32, 8'h03, 8'h04, 8'h01, 8'h02, 8'h02, 8'h01, 8'h03,
        8'h42, 8'h00, 8'h04, 8'h02, 8'h02, 8'h04, 8'h01, 8'h06,
        8'h42, 8'h01, 8'h04, 8'h04, 8'h02, 8'h05, 8'h01, 8'h07,
        8'h42, 8'h02, 8'h04, 8'h05, 8'h02, 8'h06, 8'h01, 8'h08};
    dlt_if lk();
    dlt_if lk2();
    dlt_device u_dlt_device(.clk_i(clk_i), .rst_i(rst_i), .link(lk));
    dlt_device u_dlt_device_b(.clk_i(clk_i), .rst_i(rst_i), .link(lk2));
    dlt_host u_dlt_host(.clk_i(clk_i), .rst_i(rst_i), .link(lk),
        .start_i(start_i), .code_i(code_i), .cmd_sel_i(cmd_sel_i),
        .done_o(done_o), .found_o(found_o), .supported_o(supported_o),
        .freq_o(freq_o), .mode_o(mode_o), .lat_o(lat_o));
    dlt_assertions u_dlt_assertions(.clk_i(clk_i), .rst_i(rst_i),
        .req(lk.req), .addr(lk.addr), .ack(lk.ack), .data(lk.data));
    initial forever #50 clk_i = ~clk_i;
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task walk(input logic [1:0] c, input logic [1:0] s);
        int b;
        int n;
        b = (c == 2'h3) ? 12 : 20 + 8 * c;
        n = dones + 1;
        // no row holds FFh, so supported is always expected
        res_q.push_back({2'b11, 8'h42, rom[b+2+2*s], rom[b+3+2*s]});
        @(posedge clk_i);
        start_i <= 1'b1;
        code_i <= c;
        cmd_sel_i <= s;
        @(posedge clk_i);
        start_i <= 1'b0;
        repeat (9) @(posedge clk_i);
        // a start in mid-walk must not add a second result
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        wait (dones >= n);
    endtask
    always @(negedge clk_i) begin
        if (lk.req === 1'b1) last_a = lk.addr;
        if (lk.ack === 1'b1)
            chk("link byte", rom[last_a], lk.data);
        if (lk2.ack === 1'b1)
            chk("table byte", byte_q.pop_front(), lk2.data);
        if (done_o === 1'b1) begin
            dones++;
            exp_r = res_q.pop_front();
            chk("found", 8'(exp_r[25]), 8'(found_o));
            chk("supported", 8'(exp_r[24]), 8'(supported_o));
            chk("freq", exp_r[23:16], freq_o);
            chk("mode", exp_r[15:8], mode_o);
            chk("latency", exp_r[7:0], lat_o);
        end
    end
    initial begin
        #300000;
        failures++;
        complete_run();
    end
    initial begin
        lk2.req = 1'b0;
        lk2.addr = 6'h00;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // past the last byte the device answers FFh
        for (int a = 0; a < 48; a++) begin
            @(posedge clk_i);
            lk2.req <= 1'b1;
            lk2.addr <= 6'(a);
            byte_q.push_back(a < 44 ? rom[a] : 8'hFF);
            @(posedge clk_i);
            lk2.req <= 1'b0;
        end
        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 3; s++)
                walk(2'(c), 2'(s));
        repeat (4)
            walk(2'($random(seed)), 2'($unsigned($random(seed)) % 3));
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule
